// File: rtl/gpb_port.sv
// Contract
// - each latch and direction bit drives one pin, bit 7 the top pin.
// - reading the data register gives the pin levels, not the latch.
// - bit set and bit clear work on the latch so other bits stay put.
// - direction 1 enables the driver, direction 0 leaves the pin floating.
// - a data write with wstrb[0] set loads the latch and drives an output pin.
// - on an input pin a data write loads the latch but drives nothing.
// - an enabled peripheral output owns the pin's value and enable.
// - while a peripheral drives a pin, readback shows its output level.
// - pin levels reach the peripherals except in stop or watch mode.
// - reset clears every direction bit so all pins float as inputs.
// - reset leaves the output latch untouched and undefined.
// - stop or watch with pin float set turns every driver off.
// - stop or watch with pin float set holds the input path fixed.
// - pin float lives in standby control; clear keeps pins driven.
`timescale 1ns/1ps
`default_nettype none

module gpb_port
    import gpb_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // axi4-lite write address and data
    input  wire logic [GPB_AW-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // axi4-lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // axi4-lite read
    input  wire logic [GPB_AW-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // low-power mode state from the clock controller
    input  wire logic              lp_stop,
    input  wire logic              lp_watch,
    // shared peripherals
    input  wire gpb_periph_t       periph,
    output logic [7:0]             periph_in,
    // pins
    input  wire logic [7:0]        pin_i,
    output var gpb_pin_drv_t       pin_drv
);

    logic [7:0]    port_output_latch;
    logic [7:0]    port_direction;
    logic          standby_pin_float;
    logic [7:0]    pin_sync;
    logic [7:0]    pin_level;
    logic          lp_any;
    logic          float_active;

    logic          aw_held;
    logic          w_held;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    gpb_wr_state_t wr_state;
    logic          aw_take;
    logic          w_take;
    logic          do_write;
    logic          next_aw_held;
    logic          next_w_held;
    gpb_sel_t      wr_sel;
    logic          ar_take;
    gpb_sel_t      rd_sel;
    logic [31:0]   next_rdata;
    gpb_pin_drv_t  next_pin_drv;

    // awprot and arprot carry no meaning for this block
    logic unused_prot;
    assign unused_prot = ^{awprot, arprot, wstrb[3:1]};

    gpb_pin_sync u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .d       (pin_i),
        .q       (pin_sync)
    );

    assign lp_any       = lp_stop | lp_watch;
    assign float_active = lp_any & standby_pin_float;

    // the gate keeps a floating pin from reaching the data register readback
    assign pin_level = float_active ? GPB_IN_FIXED : pin_sync;

    // write channel: address and data are caught in either order
    assign aw_take  = awvalid & awready;
    assign w_take   = wvalid & wready;
    assign do_write = aw_held & w_held & (wr_state == GPB_WR_IDLE);
    assign next_aw_held = (aw_held | aw_take) & ~do_write;
    assign next_w_held  = (w_held | w_take) & ~do_write;
    assign wr_sel   = gpb_decode(aw_addr);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'h0;
            w_held  <= 1'h0;
            awready <= 1'h0;
            wready  <= 1'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            awready <= ~next_aw_held;
            wready  <= ~next_w_held;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aw_addr <= 8'h00;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr <= awaddr;
            end
            if (w_take) begin
                w_data <= wdata;
                w_strb <= wstrb;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wr_state <= GPB_WR_IDLE;
            bvalid   <= 1'h0;
            bresp    <= GPB_RESP_OKAY;
        end else begin
            case (wr_state)
                GPB_WR_IDLE: begin
                    if (do_write) begin
                        wr_state <= GPB_WR_RESP;
                        bvalid   <= 1'h1;
                        bresp    <= (wr_sel == GPB_SEL_NONE) ?
                                    GPB_RESP_SLVERR : GPB_RESP_OKAY;
                    end
                end
                GPB_WR_RESP: begin
                    if (bready) begin
                        wr_state <= GPB_WR_IDLE;
                        bvalid   <= 1'h0;
                    end
                end
                default: begin
                    wr_state <= GPB_WR_IDLE;
                    bvalid   <= 1'h0;
                end
            endcase
        end
    end

    // no reset on purpose: the latch keeps whatever it held
    always_ff @(posedge ref_clk) begin
        if (do_write && w_strb[0]) begin
            case (wr_sel)
                GPB_SEL_LATCH: port_output_latch <= w_data[7:0];
                GPB_SEL_SET:
                    port_output_latch <= port_output_latch | w_data[7:0];
                GPB_SEL_CLR:
                    port_output_latch <= port_output_latch & ~w_data[7:0];
                default: port_output_latch <= port_output_latch;
            endcase
        end
    end // set and clear merge with the latch, never the pins

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_direction <= GPB_DIR_RST;
        end else if (do_write && w_strb[0] && wr_sel == GPB_SEL_DIR) begin
            port_direction <= w_data[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            standby_pin_float <= GPB_FLOAT_RST;
        end else if (do_write && w_strb[0] && wr_sel == GPB_SEL_STBY) begin
            standby_pin_float <= w_data[GPB_STBY_FLOAT_BIT];
        end
    end

    // read channel: one read in flight, answer one edge after the take
    assign ar_take = arvalid & arready;
    assign rd_sel  = gpb_decode(araddr);

    always_comb begin
        next_rdata = GPB_RDATA_RST;
        case (rd_sel)
            GPB_SEL_LATCH: next_rdata[7:0] = pin_level;
            GPB_SEL_DIR:   next_rdata[7:0] = port_direction;
            GPB_SEL_STBY: begin
                next_rdata[GPB_STBY_FLOAT_BIT] = standby_pin_float;
                next_rdata[GPB_STBY_STOP_BIT]  = lp_stop;
                next_rdata[GPB_STBY_WATCH_BIT] = lp_watch;
            end
            GPB_SEL_SET:   next_rdata[7:0] = port_output_latch;
            GPB_SEL_CLR:   next_rdata[7:0] = port_output_latch;
            default:       next_rdata = GPB_RDATA_RST;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'h0;
            rvalid  <= 1'h0;
            rdata   <= GPB_RDATA_RST;
            rresp   <= GPB_RESP_OKAY;
        end else if (ar_take) begin
            arready <= 1'h0;
            rvalid  <= 1'h1;
            rdata   <= next_rdata;
            rresp   <= (rd_sel == GPB_SEL_NONE) ?
                       GPB_RESP_SLVERR : GPB_RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid  <= 1'h0;
            arready <= 1'h1;
        end else if (!rvalid) begin
            arready <= 1'h1;
        end
    end

    // pin drive, one vector bit per pin, bit 7 the highest pin
    always_comb begin
        next_pin_drv.oe = periph.oe | port_direction;
        next_pin_drv.o  = (periph.oe & periph.out) |
                          (~periph.oe & port_direction &
                           port_output_latch);
        if (float_active) begin
            next_pin_drv.oe = 8'h00;
            next_pin_drv.o  = 8'h00;
        end
    end

    // registered drive makes writes show on the pins one edge later
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_drv.o  <= 8'h00;
            pin_drv.oe <= 8'h00;
        end else begin
            pin_drv <= next_pin_drv;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            periph_in <= GPB_IN_FIXED;
        end else begin
            periph_in <= lp_any ? GPB_IN_FIXED : pin_sync;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_reset_dir_clear: assert property (
        !$past(nrst) |-> (port_direction == GPB_DIR_RST &&
                          pin_drv.oe == 8'h00))
        else $error("direction not cleared after reset");

    a_latch_to_pin: assert property (
        !float_active |=> ((pin_drv.o & ~$past(periph.oe) &
                            $past(port_direction)) ==
                           ($past(port_output_latch) & ~$past(periph.oe) &
                            $past(port_direction))))
        else $error("output pin does not follow latch");

    a_input_undriven: assert property (
        1'b1 |=> ((pin_drv.oe & ~$past(periph.oe) &
                   ~$past(port_direction)) == 8'h00))
        else $error("input pin is driven");

    a_periph_override: assert property (
        // the release edge still sees reset drive, so it is left out
        nrst && !float_active |=> ((pin_drv.oe & $past(periph.oe)) ==
                           $past(periph.oe) &&
                           (pin_drv.o & $past(periph.oe)) ==
                           ($past(periph.out) & $past(periph.oe))))
        else $error("peripheral does not own its pin");

    a_float_hiz: assert property (
        float_active |=> (pin_drv.oe == 8'h00))
        else $error("driver on during pin float");

    a_lp_input_hold: assert property (
        lp_any |=> (periph_in == GPB_IN_FIXED))
        else $error("peripheral input not held in low power");

    a_read_pins: assert property (
        (ar_take && rd_sel == GPB_SEL_LATCH && !float_active)
        |=> (rvalid && rdata[7:0] == $past(pin_sync)))
        else $error("data read does not show pin level");

    a_read_fixed: assert property (
        (ar_take && rd_sel == GPB_SEL_LATCH && float_active)
        |=> (rdata[7:0] == GPB_IN_FIXED))
        else $error("floating pin reaches readback");

    a_bit_set_keep: assert property (
        (do_write && w_strb[0] && wr_sel == GPB_SEL_SET)
        |=> (port_output_latch ==
             ($past(port_output_latch) | $past(w_data[7:0]))))
        else $error("bit set disturbs other latch bits");

    a_input_write_latch: assert property (
        (do_write && w_strb[0] && wr_sel == GPB_SEL_LATCH)
        |=> (port_output_latch == $past(w_data[7:0])) ##1
            ((pin_drv.oe & ~$past(periph.oe) &
              ~$past(port_direction)) == 8'h00))
        else $error("latch write lost or drives an input pin");

    a_write_answer: assert property (
        do_write |=> (bvalid && awready && wready))
        else $error("write response missing");

    a_bit_clear_keep: assert property (
        (do_write && w_strb[0] && wr_sel == GPB_SEL_CLR)
        |=> (port_output_latch ==
             ($past(port_output_latch) & ~$past(w_data[7:0]))))
        else $error("bit clear disturbs other latch bits");

    a_dir_write_next: assert property (
        (do_write && w_strb[0] && wr_sel == GPB_SEL_DIR)
        |=> (port_direction == $past(w_data[7:0])))
        else $error("direction write not taken at next edge");

endmodule // gpb_port

`default_nettype wire

// File: common/gpb_pkg.sv
package gpb_pkg;

    localparam int GPB_AW = 8;

    // register indices; the byte address is four times the index
    localparam logic [7:0] GPB_IDX_LATCH = 8'h12;
    localparam logic [7:0] GPB_IDX_DIR   = 8'h13;
    localparam logic [7:0] GPB_IDX_STBY  = 8'h14;
    localparam logic [7:0] GPB_IDX_SET   = 8'h15;
    localparam logic [7:0] GPB_IDX_CLR   = 8'h16;

    localparam logic [7:0] GPB_ADDR_LATCH = {GPB_IDX_LATCH[5:0], 2'h0};
    localparam logic [7:0] GPB_ADDR_DIR   = {GPB_IDX_DIR[5:0], 2'h0};
    localparam logic [7:0] GPB_ADDR_STBY  = {GPB_IDX_STBY[5:0], 2'h0};
    localparam logic [7:0] GPB_ADDR_SET   = {GPB_IDX_SET[5:0], 2'h0};
    localparam logic [7:0] GPB_ADDR_CLR   = {GPB_IDX_CLR[5:0], 2'h0};

    // standby control field positions
    localparam int GPB_STBY_FLOAT_BIT = 0;
    localparam int GPB_STBY_STOP_BIT  = 1;
    localparam int GPB_STBY_WATCH_BIT = 2;

    // values after reset and fixed levels
    localparam logic [7:0]  GPB_DIR_RST   = 8'h00;
    localparam logic        GPB_FLOAT_RST = 1'h0;
    localparam logic [7:0]  GPB_IN_FIXED  = 8'h00;
    localparam logic [31:0] GPB_RDATA_RST = 32'h0;

    localparam logic [1:0] GPB_RESP_OKAY   = 2'h0;
    localparam logic [1:0] GPB_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] out;
    } gpb_periph_t;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } gpb_pin_drv_t;

    typedef enum logic [2:0] {
        GPB_SEL_LATCH,
        GPB_SEL_DIR,
        GPB_SEL_STBY,
        GPB_SEL_SET,
        GPB_SEL_CLR,
        GPB_SEL_NONE
    } gpb_sel_t;

    typedef enum logic {
        GPB_WR_IDLE,
        GPB_WR_RESP
    } gpb_wr_state_t;

    function automatic gpb_sel_t gpb_decode(input logic [7:0] a);
        case (a)
            GPB_ADDR_LATCH: gpb_decode = GPB_SEL_LATCH;
            GPB_ADDR_DIR:   gpb_decode = GPB_SEL_DIR;
            GPB_ADDR_STBY:  gpb_decode = GPB_SEL_STBY;
            GPB_ADDR_SET:   gpb_decode = GPB_SEL_SET;
            GPB_ADDR_CLR:   gpb_decode = GPB_SEL_CLR;
            default:        gpb_decode = GPB_SEL_NONE;
        endcase
    endfunction

endpackage

// File: rtl/gpb_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module gpb_pin_sync (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // asynchronous pin levels in, synchronised levels out
    input  wire logic [7:0] d,
    output logic      [7:0] q
);

    logic [7:0] meta;

    // meta feeds only the second stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta <= 8'h00;
            q    <= 8'h00;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // gpb_pin_sync

`default_nettype wire

// File: verif/gpb_board.sv
`timescale 1ns/1ps
`default_nettype none

module gpb_board
    import gpb_pkg::*;
(
    // chip side of the pins
    input  wire gpb_pin_drv_t drv,
    output logic [7:0]        pin_i,
    // level the board puts on pins that the chip leaves off
    input  wire logic [7:0]   ext_val
);
    // the board drives every released pin, so no level is left to chance;
    // where the chip drives, its value reaches the pin and the readback
    always_comb pin_i = (drv.oe & drv.o) | (~drv.oe & ext_val);
endmodule // gpb_board

`default_nettype wire

// File: verif/gpb_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module gpb_port_tb
    import gpb_pkg::*;
;
    localparam logic [1:0] OK = GPB_RESP_OKAY;
    logic         ref_clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic         awready, wready, bvalid, arready, rvalid, lp_stop, lp_watch;
    logic         pin_probe, m_float;
    logic [7:0]   awaddr, araddr, ext, periph_in, pin_i, m_latch, m_dir;
    logic [31:0]  wdata, rdata;
    logic [3:0]   wstrb;
    logic [2:0]   prot;
    logic [1:0]   bresp, rresp;
    gpb_periph_t  periph;
    gpb_pin_drv_t pin_drv;
    int           n_errors, samples_checked, seed;
    logic [1:0]   exp_b[$];
    logic [33:0]  exp_r[$];
    logic [23:0]  exp_p[$];

    gpb_port DUT (.ref_clk(ref_clk), .nrst(nrst), .awaddr(awaddr),
        .awprot(prot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(prot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .lp_stop(lp_stop),
        .lp_watch(lp_watch), .periph(periph), .periph_in(periph_in),
        .pin_i(pin_i), .pin_drv(pin_drv));

    gpb_board board (.drv(pin_drv), .pin_i(pin_i), .ext_val(ext));

    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic tally(input logic ok, input logic [63:0] got, exp);
        samples_checked++;
        if (!ok) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic [1:0] got, exp);
        tally(got === exp, 64'(got), 64'(exp));
    endtask
    task automatic chk_r(input logic [33:0] got, exp);
        tally(got === exp, 64'(got), 64'(exp));
    endtask
    task automatic chk_p(input logic [23:0] got, exp);
        tally(got === exp, 64'(got), 64'(exp));
    endtask

    // results are matched in the order the driver noted them
    always @(posedge ref_clk) begin
        if (bvalid === 1'b1 && bready === 1'b1)
            chk_b(bresp, exp_b.pop_front());
        if (rvalid === 1'b1 && rready === 1'b1)
            chk_r({rresp, rdata}, exp_r.pop_front());
        if (pin_probe === 1'b1)
            chk_p({pin_drv, periph_in}, exp_p.pop_front());
    end

    task automatic wr(input logic [7:0] a, d, input logic [3:0] s,
                      input logic [1:0] r);
        int n;
        @(posedge ref_clk);
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= {24'($random(seed)), d};
        wstrb <= s;
        prot <= 3'($random(seed));
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            give_verdict();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        @(posedge ref_clk);
        exp_r.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            give_verdict();
        end
    endtask

    // expected {drive value, drive enable, pin level}
    function automatic logic [23:0] exp_pins();
        logic [7:0] oe, o;
        oe = periph.oe | m_dir;
        o = ((periph.oe & periph.out) | (~periph.oe & m_latch)) & oe;
        if (m_float && (lp_stop || lp_watch)) begin
            oe = 8'h00;
            o = 8'h00;
        end
        return {o, oe, (o & oe) | (ext & ~oe)};
    endfunction

    // waits out the two synchroniser stages before looking at the pins
    task automatic check_all(input string name);
        logic [23:0] e;
        logic        lp;
        repeat (4) @(posedge ref_clk);
        e = exp_pins();
        lp = lp_stop | lp_watch;
        exp_p.push_back({e[23:8], lp ? 8'h00 : e[7:0]});
        pin_probe <= 1'b1;
        @(posedge ref_clk);
        pin_probe <= 1'b0;
        rd(GPB_ADDR_LATCH, {24'h0, (lp && m_float) ? 8'h00 : e[7:0]}, OK);
        $display("test %s done", name);
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        m_dir = 8'h00;
        m_float = 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
    endtask

    initial begin
        #40000;
        n_errors++;
        give_verdict();
    end

    initial begin
        seed = 60562;
        n_errors = 0;
        samples_checked = 0;
        {awvalid, wvalid, bready, arvalid, rready, pin_probe} = '0;
        {awaddr, araddr, wdata, wstrb, prot} = '0;
        {lp_stop, lp_watch} = 2'h0;
        periph = '0;
        ext = 8'h3c;
        m_latch = 8'hxx;
        do_reset();
        rd(GPB_ADDR_DIR, 32'h0, OK);
        rd(GPB_ADDR_STBY, 32'h0, OK);
        rd(GPB_ADDR_SET, {24'h0, 8'hxx}, OK);
        check_all("reset");
        // latch first, then direction, as software must
        wr(GPB_ADDR_LATCH, 8'h5a, 4'hf, OK);
        m_latch = 8'h5a;
        check_all("latch_on_inputs");
        wr(GPB_ADDR_DIR, 8'h0f, 4'h1, OK);
        m_dir = 8'h0f;
        check_all("low_half_out");
        wr(GPB_ADDR_LATCH, 8'hc3, 4'h1, OK);
        m_latch = 8'hc3;
        check_all("drive_now");
        wr(GPB_ADDR_SET, 8'h81, 4'h1, OK);
        wr(GPB_ADDR_CLR, 8'h42, 4'h1, OK);
        m_latch = (m_latch | 8'h81) & ~8'h42;
        rd(GPB_ADDR_CLR, {24'h0, m_latch}, OK);
        check_all("set_clear");
        // strobe off and unmapped places must leave the latch alone
        wr(GPB_ADDR_LATCH, 8'hff, 4'he, OK);
        wr(8'h00, 8'hff, 4'hf, GPB_RESP_SLVERR);
        rd(8'hfc, 32'h0, GPB_RESP_SLVERR);
        rd(GPB_ADDR_SET, {24'h0, m_latch}, OK);
        periph <= {8'h30, 8'h10};
        check_all("periph_out");
        wr(GPB_ADDR_DIR, 8'h07, 4'h1, OK);
        m_dir = 8'h07;
        ext <= 8'hc5;
        check_all("periph_in");
        for (int i = 0; i < 4; i++) begin
            lp_stop <= i[0];
            lp_watch <= ~i[0];
            m_float = i[1];
            wr(GPB_ADDR_STBY, {7'h0, m_float}, 4'h1, OK);
            rd(GPB_ADDR_STBY, {29'h0, lp_watch, lp_stop, m_float}, OK);
            check_all("standby");
        end
        lp_stop <= 1'b0;
        lp_watch <= 1'b0;
        check_all("wake");
        do_reset();
        rd(GPB_ADDR_SET, {24'h0, m_latch}, OK);
        rd(GPB_ADDR_DIR, 32'h0, OK);
        check_all("second_reset");
        for (int i = 0; i < 12; i++) begin
            ext <= 8'($random(seed));
            periph <= 16'($random(seed));
            m_latch = 8'($random(seed));
            m_dir = 8'($random(seed));
            wr(GPB_ADDR_LATCH, m_latch, 4'hf, OK);
            wr(GPB_ADDR_DIR, m_dir, 4'h1, OK);
            rd(GPB_ADDR_DIR, {24'h0, m_dir}, OK);
            check_all("random");
        end
        give_verdict();
    end
endmodule // gpb_port_tb

`default_nettype wire
